// file: inc/occ_pkg.sv
// occ_pkg: constants for the output configuration select control block.
// assumes: a plain register port with byte addresses and 32-bit words.
package occ_pkg;

    // sizes
    localparam int OCC_NUM_OUT = 3;
    localparam int OCC_NUM_CFG = 4;
    localparam int OCC_SEL_W = 2;
    localparam int OCC_ADDR_W = 8;
    localparam int OCC_DATA_W = 32;

    // register byte addresses
    localparam logic [7:0] OCC_CFG0_ADDR = 8'h00;
    localparam logic [7:0] OCC_CFG1_ADDR = 8'h04;
    localparam logic [7:0] OCC_CFG2_ADDR = 8'h08;
    localparam logic [7:0] OCC_CFG3_ADDR = 8'h0C;
    localparam logic [7:0] OCC_STAT_ADDR = 8'h10;
    // the slot index sits just above the byte lanes of a word
    localparam int OCC_WORD_LSB = 2;

    // configuration slot fields
    localparam int OCC_CFG_EN_LSB = 0;
    localparam int OCC_CFG_DIFF_BIT = 3;
    localparam int OCC_CFG_HIZ_LSB = 4;
    localparam int OCC_CFG_W = 7;
    // blank slot: every output off, low idle, single ended
    localparam logic [6:0] OCC_CFG_RESET = 7'h00;

    // status fields
    localparam int OCC_STAT_SEL_LSB = 0;
    localparam int OCC_STAT_ACT_LSB = 2;
    localparam int OCC_STAT_RUN_BIT = 5;
    localparam int OCC_STAT_DIFF_BIT = 6;
    localparam int OCC_STAT_HIZ_LSB = 7;

    // the differential pair is outputs 0 and 1, governed by gate pin 1
    localparam int OCC_DIFF_GATE_IDX = 1;
    localparam int OCC_PAIR_OUTS = 2;

    // output buffer state
    typedef enum logic [1:0] {
        OCC_BUF_LOW = 2'b00,
        OCC_BUF_RUN = 2'b01,
        OCC_BUF_HIZ = 2'b10
    } occ_buf_t;

endpackage

// file: logic/occ_select_ctrl.sv
// occ_select_ctrl: configuration select, output gating and power-down control.
// assumes: pins already synchronous to clk_sys; the pad pull-down on the
// power-down pin is modelled by the power_down_driven input.
// limitation: a live selector change switches at once; relock time is left to the board.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module occ_select_ctrl
    import occ_pkg::*;
#(
    parameter int NUM_OUT = OCC_NUM_OUT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [OCC_ADDR_W-1:0] reg_addr,
    input wire logic [OCC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [OCC_DATA_W-1:0] reg_rdata,
    // control pins
    input wire logic [OCC_SEL_W-1:0] cfg_select,
    input wire logic [NUM_OUT-1:0] output_gate_pin,
    input wire logic power_down_n,
    input wire logic power_down_driven,
    // core and output buffer control
    output logic core_run,
    output logic [OCC_SEL_W-1:0] cfg_applied,
    output logic diff_mode,
    output logic [NUM_OUT-1:0] out_run,
    output logic [NUM_OUT-1:0] out_drive_low,
    output logic [NUM_OUT-1:0] out_hiz
);

////////////////////////////////////////////////////////////////////////////////
// configuration slots and register port

    logic [OCC_CFG_W-1:0] cfg_reg [OCC_NUM_CFG];
    logic [OCC_DATA_W-1:0] rdata_reg;
    logic [OCC_DATA_W-1:0] rdata_next;
    logic [OCC_DATA_W-1:0] stat_word;
    logic [OCC_CFG_W-1:0] sel_word;
    logic [OCC_CFG_W-1:0] read_cfg;
    logic is_cfg;
    logic is_stat;
    logic addr_aligned;
    logic addr_in_slots;
    logic slot_wr;
    logic [OCC_SEL_W-1:0] cfg_idx;

    // an offset inside a word is refused rather than aliased onto a slot
    assign addr_aligned = (reg_addr[OCC_WORD_LSB-1:0] == '0);
    assign addr_in_slots = (reg_addr >= OCC_CFG0_ADDR) && (reg_addr <= OCC_CFG3_ADDR);
    assign is_cfg = addr_in_slots && addr_aligned;
    assign is_stat = (reg_addr == OCC_STAT_ADDR);
    assign cfg_idx = reg_addr[OCC_WORD_LSB +: OCC_SEL_W];
    assign slot_wr = reg_wr && is_cfg;
    assign read_cfg = cfg_reg[cfg_idx];
    // unmapped addresses read as zero and ignore writes
    assign rdata_next = is_cfg ? {{(OCC_DATA_W-OCC_CFG_W){1'b0}}, read_cfg}
                      : is_stat ? stat_word : '0;

    // slots reset blank so no output runs until software fills one
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < OCC_NUM_CFG; i++) begin
                cfg_reg[i] <= OCC_CFG_RESET;
            end
        end else if (slot_wr) begin
            cfg_reg[cfg_idx] <= reg_wdata[OCC_CFG_W-1:0];
        end
    end

    // read data falls back to zero after its cycle so a stale word never lingers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : '0;
        end
    end

    assign reg_rdata = rdata_reg;

////////////////////////////////////////////////////////////////////////////////
// power-down and slot selection

    logic pd_level;
    logic run_reg;
    logic [OCC_SEL_W-1:0] applied_reg;
    logic [OCC_SEL_W-1:0] applied_next;
    logic diff_reg;
    logic diff_next;
    logic pair_sel;

    // an undriven pin is pulled low, so power stays off
    assign pd_level = power_down_driven & power_down_n;
    // selector used straight as the slot index, live at every cycle
    assign sel_word = cfg_reg[cfg_select];
    // held at slot 0 while powered down so restart begins from a known slot
    assign applied_next = pd_level ? cfg_select : '0;
    // pair mode comes from the selected slot, so a live switch can change it
    assign pair_sel = sel_word[OCC_CFG_DIFF_BIT];
    assign diff_next = pd_level & pair_sel;

    // core run depends on power-down alone, never on gate pins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_reg <= 1'b0;
            applied_reg <= '0;
            diff_reg <= 1'b0;
        end else begin
            run_reg <= pd_level;
            applied_reg <= applied_next;
            diff_reg <= diff_next;
        end
    end

    assign core_run = run_reg;
    assign cfg_applied = applied_reg;
    assign diff_mode = diff_reg;

////////////////////////////////////////////////////////////////////////////////
// per-output buffer control

    occ_buf_t buf_next [NUM_OUT];
    logic [NUM_OUT-1:0] gate_eff;
    logic [NUM_OUT-1:0] slot_en;
    logic [NUM_OUT-1:0] slot_hiz;
    logic [NUM_OUT-1:0] run_reg_o;
    logic [NUM_OUT-1:0] low_reg_o;
    logic [NUM_OUT-1:0] hiz_reg_o;

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            // slot fields for this output, taken from the selected slot
            assign slot_en[g] = sel_word[OCC_CFG_EN_LSB+g];
            assign slot_hiz[g] = sel_word[OCC_CFG_HIZ_LSB+g];

            // pair members both follow the pair's gate pin; gate pin 0 is then ignored
            if (g < OCC_PAIR_OUTS) begin : g_pair
                assign gate_eff[g] = pair_sel
                                     ? output_gate_pin[OCC_DIFF_GATE_IDX]
                                     : output_gate_pin[g];
            end else begin : g_single
                assign gate_eff[g] = output_gate_pin[g];
            end

            always_comb begin
                if (!pd_level) begin
                    buf_next[g] = OCC_BUF_LOW;
                end else if (slot_en[g] && gate_eff[g]) begin
                    buf_next[g] = OCC_BUF_RUN;
                end else if (slot_hiz[g]) begin
                    buf_next[g] = OCC_BUF_HIZ;
                end else begin
                    buf_next[g] = OCC_BUF_LOW;
                end
            end

            // three flags from one state, so exactly one is ever high
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    run_reg_o[g] <= 1'b0;
                    low_reg_o[g] <= 1'b1;
                    hiz_reg_o[g] <= 1'b0;
                end else begin
                    run_reg_o[g] <= (buf_next[g] == OCC_BUF_RUN);
                    low_reg_o[g] <= (buf_next[g] == OCC_BUF_LOW);
                    hiz_reg_o[g] <= (buf_next[g] == OCC_BUF_HIZ);
                end
            end
        end
    endgenerate

    assign out_run = run_reg_o;
    assign out_drive_low = low_reg_o;
    assign out_hiz = hiz_reg_o;

    // status: applied slot, running outputs, core run, pair mode, idle hiz
    assign stat_word = {{(OCC_DATA_W-OCC_STAT_HIZ_LSB-NUM_OUT){1'b0}}, hiz_reg_o,
                        diff_reg, run_reg, run_reg_o, applied_reg};

////////////////////////////////////////////////////////////////////////////////
// checks

    // every check runs on the one clock and sleeps through reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_sel_applied: assert property (pd_level |=> cfg_applied == $past(cfg_select))
        else $error("applied slot does not follow selector");
    a_run_needs_both: assert property (out_run[2] |->
        $past(output_gate_pin[2]) && $past(sel_word[OCC_CFG_EN_LSB+2]))
        else $error("output 2 runs without both enables");
    a_gate_index: assert property ((pd_level && sel_word[OCC_CFG_EN_LSB]
        && !sel_word[OCC_CFG_DIFF_BIT]) |=> out_run[0] == $past(output_gate_pin[0]))
        else $error("output 0 not governed by gate pin 0");
    a_core_indep: assert property ((pd_level && $changed(output_gate_pin))
        |=> core_run)
        else $error("gate pin change stopped the core");
    a_pair_gate: assert property ((pd_level && sel_word[OCC_CFG_DIFF_BIT]
        && sel_word[OCC_CFG_EN_LSB]) |=> out_run[0] == $past(output_gate_pin[1]))
        else $error("pair output 0 not following gate pin 1");
    a_idle_state: assert property ((pd_level && !output_gate_pin[2]) |=>
        (out_hiz[2] == $past(sel_word[OCC_CFG_HIZ_LSB+2])) && !out_run[2])
        else $error("disabled output idle state wrong");
    a_pd_low: assert property (!pd_level |=>
        (out_drive_low == '1) && !core_run && (out_run == '0) && (out_hiz == '0))
        else $error("power down did not force outputs low");
    a_undriven_off: assert property (!power_down_driven |=> !core_run)
        else $error("undriven power-down pin left core running");
    a_run_only_up: assert property (core_run |-> $past(pd_level))
        else $error("core runs without power-down high");
    a_one_hot_buf: assert property (
        $onehot({out_run[1], out_drive_low[1], out_hiz[1]}))
        else $error("output 1 buffer state not one-hot");
    a_read_data: assert property ((reg_rd && is_stat) |=> reg_rdata == $past(stat_word))
        else $error("status read data wrong");

    // selection and power-down
    a_core_up: assert property (pd_level |=> core_run)
        else $error("core stopped while power-down high");
    a_undriven_low: assert property (!power_down_driven |=> out_drive_low == '1)
        else $error("undriven power-down pin left an output not low");
    a_pd_slot_zero: assert property (!pd_level |=>
        (cfg_applied == '0) && !diff_mode)
        else $error("slot or pair mode kept while powered down");
    a_diff_needs_pd: assert property (diff_mode |-> $past(pd_level))
        else $error("pair mode shown while powered down");
    a_hiz_needs_pd: assert property ((out_hiz != '0) |-> $past(pd_level))
        else $error("high impedance idle while powered down");
    a_applied_live: assert property ((pd_level && $changed(cfg_select))
        |=> cfg_applied == $past(cfg_select))
        else $error("live selector change not applied");
    a_slot_index: assert property (pd_level |=>
        out_run[2] == $past(cfg_reg[cfg_select][OCC_CFG_EN_LSB+2] && output_gate_pin[2]))
        else $error("selector did not address its slot directly");
    a_gate_keeps_slot: assert property ((pd_level && $past(pd_level)
        && $changed(output_gate_pin) && $stable(cfg_select)) |=> $stable(cfg_applied))
        else $error("gate pin change disturbed the applied slot");

    // differential pair and single output 2
    a_pair_mode: assert property (pd_level |=>
        diff_mode == $past(sel_word[OCC_CFG_DIFF_BIT]))
        else $error("pair mode not taken from the selected slot");
    a_pair_out1: assert property ((pd_level && sel_word[OCC_CFG_DIFF_BIT]
        && sel_word[OCC_CFG_EN_LSB+1]) |=> out_run[1] == $past(output_gate_pin[1]))
        else $error("pair output 1 not following gate pin 1");
    a_out2_single: assert property ((pd_level && sel_word[OCC_CFG_EN_LSB+2])
        |=> out_run[2] == $past(output_gate_pin[2]))
        else $error("output 2 not governed by gate pin 2");

    // register port
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data stood beyond its cycle");
    a_unmapped_read: assert property ((reg_rd && !is_cfg && !is_stat) |=> reg_rdata == '0)
        else $error("unmapped address read non-zero");
    a_slot_read: assert property ((reg_rd && is_cfg)
        |=> reg_rdata[OCC_CFG_W-1:0] == $past(read_cfg))
        else $error("slot read data wrong");
    a_slot_upper_zero: assert property ((reg_rd && is_cfg)
        |=> reg_rdata[OCC_DATA_W-1:OCC_CFG_W] == '0)
        else $error("unused slot bits read non-zero");
    a_slot_write: assert property (slot_wr
        |=> cfg_reg[$past(cfg_idx)] == $past(reg_wdata[OCC_CFG_W-1:0]))
        else $error("slot write did not land");

    // per-output checks, one copy for each buffer
    generate
        for (genvar k = 0; k < NUM_OUT; k++) begin : g_chk
            a_buf_one_hot: assert property (
                $onehot({out_run[k], out_drive_low[k], out_hiz[k]}))
                else $error("buffer state not one-hot");
            a_run_needs_en: assert property (out_run[k] |->
                $past(pd_level) && $past(sel_word[OCC_CFG_EN_LSB+k]))
                else $error("output ran with its slot enable low");
            a_idle_from_slot: assert property (
                (pd_level && !sel_word[OCC_CFG_EN_LSB+k])
                |=> out_hiz[k] == $past(sel_word[OCC_CFG_HIZ_LSB+k]))
                else $error("disabled output idle not taken from its slot");
            a_idle_low: assert property (
                (pd_level && !sel_word[OCC_CFG_EN_LSB+k] && !sel_word[OCC_CFG_HIZ_LSB+k])
                |=> out_drive_low[k])
                else $error("disabled output not driven low");
        end
    endgenerate

    c_live_switch: cover property (pd_level && $changed(cfg_select) ##1 pd_level);
    c_pair_run: cover property (diff_mode && out_run[0] && out_run[1]);
    c_hiz_idle: cover property (core_run && out_hiz != '0);
    c_power_cycle: cover property (core_run ##1 !core_run ##[1:8] core_run);
    c_pd_release: cover property (!pd_level ##1 pd_level ##1 core_run);

endmodule

// file: test/occ_board_model.sv
// occ_board_model: board logic driving the select, gate and power-down pins.
// assumes: shares the device clock; the bench issues the commands.
`timescale 1ns/1ps
module occ_board_model #(
    parameter int RELOCK_CYCLES = 8
) (
    // clock
    input wire logic clk_sys,
    // commands from the bench
    input wire logic [1:0] want_sel,
    input wire logic [2:0] want_gate,
    input wire logic want_pd_n,
    input wire logic want_driven,
    // pins toward the device
    output logic [1:0] cfg_select,
    output logic [2:0] output_gate_pin,
    output logic power_down_n,
    output logic power_down_driven,
    // clocks usable again
    output logic clocks_ready
);
    int wait_cnt = 0;
    initial begin
        cfg_select = 2'h0;
        output_gate_pin = 3'h0;
        power_down_n = 1'b0;
        power_down_driven = 1'b0;
    end
    always @(posedge clk_sys) begin
        cfg_select <= want_sel;
        output_gate_pin <= want_gate;
        // released pin falls to its pull-down level
        power_down_n <= want_driven & want_pd_n;
        power_down_driven <= want_driven;
        // a live select change needs the core to relock before use
        if (want_sel != cfg_select) wait_cnt <= RELOCK_CYCLES;
        else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    end
    assign clocks_ready = (wait_cnt == 0);
endmodule

// file: test/tb_occ_select_ctrl.sv
// tb_occ_select_ctrl: self-checking bench for the select control block.
// assumes: pins come through occ_board_model; slots written over the register port.
`timescale 1ns/1ps
module tb_occ_select_ctrl;
    import occ_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd_val;
    logic [1:0] want_sel = 2'h0;
    logic [2:0] want_gate = 3'h0;
    logic want_pd_n = 1'b0;
    logic want_driven = 1'b0;
    logic [1:0] cfg_select, cfg_applied;
    logic [2:0] output_gate_pin, out_run, out_drive_low, out_hiz;
    logic power_down_n, power_down_driven, clocks_ready, core_run, diff_mode;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    // select, gate pins, expected run, expected hiz, expected diff
    logic [11:0] rows [8] = '{12'h3F0, 12'h120, 12'h7D4, 12'h40E,
                              12'h931, 12'h881, 12'hDA3, 12'hEC7};

    occ_board_model u_occ_board_model (.clk_sys(clk_sys), .want_sel(want_sel),
        .want_gate(want_gate), .want_pd_n(want_pd_n), .want_driven(want_driven),
        .cfg_select(cfg_select), .output_gate_pin(output_gate_pin),
        .power_down_n(power_down_n), .power_down_driven(power_down_driven),
        .clocks_ready(clocks_ready));
    occ_select_ctrl u_occ_select_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cfg_select(cfg_select), .output_gate_pin(output_gate_pin),
        .power_down_n(power_down_n), .power_down_driven(power_down_driven),
        .core_run(core_run), .cfg_applied(cfg_applied), .diff_mode(diff_mode),
        .out_run(out_run), .out_drive_low(out_drive_low), .out_hiz(out_hiz));

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd_val = reg_rdata;
    endtask

    // waits out the relock time before the outputs are judged
    task automatic pins(input logic [1:0] s, input logic [2:0] g, input logic p, input logic d);
        @(posedge clk_sys);
        want_sel <= s;
        want_gate <= g;
        want_pd_n <= p;
        want_driven <= d;
        repeat (2) @(posedge clk_sys);
        while (!clocks_ready) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        chk(out_drive_low, 32'h7);
        sys_rst <= 1'b0;
        rd(OCC_CFG0_ADDR);
        chk(rd_val, 32'h0);
        pins(2'h0, 3'h7, 1'b1, 1'b1);
        chk(out_run, 32'h0);
        chk(core_run, 32'h1);
        wr(OCC_CFG0_ADDR, 32'h07);
        wr(OCC_CFG1_ADDR, 32'h75);
        wr(OCC_CFG2_ADDR, 32'h0F);
        wr(OCC_CFG3_ADDR, 32'h3E);
        for (int i = 0; i < 8; i++) begin
            pins(rows[i][11:10], rows[i][9:7], 1'b1, 1'b1);
            chk(cfg_applied, rows[i][11:10]);
            chk(out_run, rows[i][6:4]);
            chk(out_hiz, rows[i][3:1]);
            chk(out_drive_low, 3'(~(rows[i][6:4] | rows[i][3:1])));
            chk(diff_mode, rows[i][0]);
            chk(core_run, 32'h1);
        end
        rd(OCC_STAT_ADDR);
        chk(rd_val, {22'h0, 3'b011, 2'b11, 3'b100, 2'h3});
        @(negedge clk_sys);
        chk(reg_rdata, 32'h0);
        // unmapped, unaligned and read-only places
        wr(OCC_STAT_ADDR, 32'h0);
        wr(8'h14, 32'h7F);
        rd(8'h14);
        chk(rd_val, 32'h0);
        rd(8'h05);
        chk(rd_val, 32'h0);
        rd(OCC_CFG1_ADDR);
        chk(rd_val, 32'h75);
        pins(2'h1, 3'h7, 1'b0, 1'b1);
        chk({core_run, out_run, out_hiz, out_drive_low, cfg_applied}, 32'h01C);
        pins(2'h1, 3'h7, 1'b1, 1'b0);
        chk({core_run, out_drive_low}, 32'h7);
        pins(2'h1, 3'h7, 1'b1, 1'b1);
        chk({core_run, out_run}, 32'hD);
        report_and_stop();
    end
endmodule
